// ==== src/imm_map.sv ====
`timescale 1ns/1ps
`default_nettype none
module imm_map (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                op_req,
  input  wire imm_pkg::imm_op_e    op_mode,
  input  wire logic [7:0]          op_addr,
  input  wire logic                op_we,
  input  wire logic [7:0]          op_wdata,
  output logic                     op_ready,
  output logic                     op_valid,
  output logic                     op_err,
  output logic [7:0]               op_rdata,
  input  wire logic                code_req,
  input  wire imm_pkg::imm_code_e  code_kind,
  input  wire logic [15:0]         code_pc,
  output logic                     code_ready,
  output logic                     code_valid,
  output logic [7:0]               code_data,
  input  wire logic                irq_take,
  input  wire logic [1:0]          irq_num,
  output logic                     redirect_valid,
  output logic [15:0]              redirect_addr,
  input  wire logic                prog_en,
  input  wire logic                prog_we,
  input  wire logic [12:0]         prog_addr,
  input  wire logic [7:0]          prog_data,
  output logic [7:0]               bank_regs_base
);
  import imm_pkg::*;

  typedef enum logic {IMM_IDLE, IMM_WAIT} imm_state_e;

  imm_state_e  state_r;
  logic [7:0]  stk_r, dpl_r, dph_r, stat_r, acc_r;
  logic [7:0]  stk_nxt, dpl_nxt, dph_nxt, stat_nxt, acc_nxt;
  logic        from_ram_r, is_bit_r, bit_wr_r, bit_val_r, err_r;
  logic [7:0]  mask_r, hold_addr_r, sfr_q_r;
  logic        op_valid_r, op_err_r, code_valid_r;
  logic [7:0]  op_rdata_r;
  logic        redirect_valid_r;
  logic [15:0] redirect_addr_r;
  logic [7:0]  ram_q, rom_q;

  wire op_take = op_req && (state_r == IMM_IDLE);
  wire is_dir  = (op_mode == IMM_OP_DIR);
  wire is_ind  = (op_mode == IMM_OP_IND);
  wire is_reg  = (op_mode == IMM_OP_REG);
  wire is_bit  = (op_mode == IMM_OP_BIT);
  wire is_push = (op_mode == IMM_OP_PUSH);
  wire is_pop  = (op_mode == IMM_OP_POP);
  wire is_ext  = (op_mode == IMM_OP_EXT);

  // above 7FH a direct address leaves RAM for the SFR block
  wire dir_sfr = is_dir && (op_addr > DIRECT_LIMIT);
  // bit space splits on bit 7: RAM bit area below, SFR bytes above
  wire bit_sfr = is_bit && op_addr[7];
  // only x0H/x8H SFR bytes can host bits, by construction
  wire [7:0] bit_byte = op_addr[7] ? {op_addr[7:3], 3'b000}
                      : 8'(BIT_AREA_BASE + {4'h0, op_addr[6:3]});
  wire [7:0] bit_mask = 8'(8'h01 << op_addr[2:0]);
  // bank chosen by the two program_status_word select bits
  wire [1:0] bank_sel = stat_r[STAT_BANK_MSB:STAT_BANK_LSB];
  wire [7:0] reg_addr = {3'b000, bank_sel, op_addr[2:0]};
  // stack pointer moves before the push lands
  wire [7:0] stk_inc = 8'(stk_r + 8'h01);
  wire [7:0] stk_dec = 8'(stk_r - 8'h01);

  // indirect never reaches SFRs, so upper RAM lives under them
  wire use_ram = is_ind || is_reg || is_push || is_pop
              || (is_dir && !dir_sfr) || (is_bit && !bit_sfr);
  wire use_sfr = dir_sfr || bit_sfr;

  // data addresses are one byte, kept apart from code addresses
  wire [7:0] req_ram_addr = is_reg  ? reg_addr
                          : is_push ? stk_inc
                          : is_pop  ? stk_r
                          : is_bit  ? bit_byte
                          : op_addr;
  wire [7:0] ram_addr = (state_r == IMM_WAIT) ? hold_addr_r
                                              : req_ram_addr;

  // bit writes to RAM need the old byte, so they land a cycle later
  wire rmw_we = (state_r == IMM_WAIT) && bit_wr_r && from_ram_r;
  wire [7:0] rmw_data = (ram_q & ~mask_r) | (bit_val_r ? mask_r : 8'h00);
  wire byte_we = op_take && use_ram && op_we && !is_bit && !is_pop;
  wire ram_we = byte_we || rmw_we;
  wire [7:0] ram_wdata = rmw_we ? rmw_data : op_wdata;

  wire [7:0] sfr_addr = is_bit ? bit_byte : op_addr;
  wire hit_stk  = (sfr_addr == SFR_STK);
  wire hit_dpl  = (sfr_addr == SFR_DPL);
  wire hit_dph  = (sfr_addr == SFR_DPH);
  wire hit_stat = (sfr_addr == SFR_STAT);
  wire hit_acc  = (sfr_addr == SFR_ACC);
  wire sfr_known = hit_stk || hit_dpl || hit_dph || hit_stat || hit_acc;
  // unknown SFR bytes read as zero and swallow writes
  wire [7:0] sfr_rd = hit_stk ? stk_r : hit_dpl  ? dpl_r
                    : hit_dph ? dph_r : hit_stat ? stat_r
                    : hit_acc ? acc_r : 8'h00;
  wire sfr_wr = op_take && use_sfr && op_we && sfr_known;
  wire [7:0] sfr_bitval = (sfr_rd & ~bit_mask)
                        | (op_wdata[0] ? bit_mask : 8'h00);
  wire [7:0] sfr_wval = is_bit ? sfr_bitval : op_wdata;

  always_comb begin
    stk_nxt  = stk_r;
    dpl_nxt  = dpl_r;
    dph_nxt  = dph_r;
    stat_nxt = stat_r;
    acc_nxt  = acc_r;
    if (sfr_wr && hit_stk) begin
      stk_nxt = sfr_wval;
    end else if (op_take && is_push) begin
      stk_nxt = stk_inc;
    end else if (op_take && is_pop) begin
      stk_nxt = stk_dec;
    end
    if (sfr_wr && hit_dpl) begin
      dpl_nxt = sfr_wval;
    end
    if (sfr_wr && hit_dph) begin
      dph_nxt = sfr_wval;
    end
    if (sfr_wr && hit_stat) begin
      stat_nxt = sfr_wval;
    end
    if (sfr_wr && hit_acc) begin
      acc_nxt = sfr_wval;
    end
  end

  // a single data_pointer_pair; no second copy, no select bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stk_r  <= STK_RESET;
      dpl_r  <= DPL_RESET;
      dph_r  <= DPH_RESET;
      stat_r <= STAT_RESET;
      acc_r  <= ACC_RESET;
    end else begin
      stk_r  <= stk_nxt;
      dpl_r  <= dpl_nxt;
      dph_r  <= dph_nxt;
      stat_r <= stat_nxt;
      acc_r  <= acc_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= IMM_IDLE;
    end else begin
      case (state_r)
        IMM_IDLE: state_r <= op_take ? IMM_WAIT : IMM_IDLE;
        IMM_WAIT: state_r <= IMM_IDLE;
        default:  state_r <= IMM_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      from_ram_r  <= 1'b0;
      is_bit_r    <= 1'b0;
      bit_wr_r    <= 1'b0;
      bit_val_r   <= 1'b0;
      err_r       <= 1'b0;
      mask_r      <= 8'h00;
      hold_addr_r <= 8'h00;
      sfr_q_r     <= 8'h00;
    end else if (op_take) begin
      from_ram_r  <= use_ram;
      is_bit_r    <= is_bit;
      bit_wr_r    <= is_bit && op_we;
      bit_val_r   <= op_wdata[0];
      err_r       <= is_ext;
      mask_r      <= bit_mask;
      hold_addr_r <= req_ram_addr;
      sfr_q_r     <= use_sfr ? sfr_rd : 8'h00;
    end
  end

  wire [7:0] src_byte = from_ram_r ? ram_q : sfr_q_r;
  wire [7:0] result = err_r ? 8'h00
                    : is_bit_r ? {7'h00, |(src_byte & mask_r)}
                    : src_byte;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op_valid_r <= 1'b0;
      op_err_r   <= 1'b0;
      op_rdata_r <= 8'h00;
    end else begin
      op_valid_r <= (state_r == IMM_WAIT);
      op_err_r   <= (state_r == IMM_WAIT) && err_r;
      if (state_r == IMM_WAIT) begin
        op_rdata_r <= result;
      end
    end
  end

  // code side: fetch and code_read_instruction share one store
  wire code_take = code_req && !prog_en;
  wire is_jmp = (code_kind == IMM_CODE_JMP);
  // accumulator and data_pointer_pair are implied, no address byte
  wire [15:0] dpair = {dph_r, dpl_r};
  wire [15:0] acc16 = {8'h00, acc_r};
  wire [15:0] dpair_idx = 16'(dpair + acc16);
  wire [15:0] pc_idx = 16'(code_pc + acc16);
  // immediate constant is the byte right after the opcode
  wire [15:0] pc_next = 16'(code_pc + 16'h0001);
  // tables are read from program memory only, base plus A
  wire [15:0] rom_addr = (code_kind == IMM_CODE_IMM) ? pc_next
                       : (code_kind == IMM_CODE_TBL_DP) ? dpair_idx
                       : (code_kind == IMM_CODE_TBL_PC) ? pc_idx
                       : code_pc;
  wire rom_rd = code_take && !is_jmp;
  // vector = 0003H + 8 * source number
  wire [15:0] vec_addr = 16'(VEC_BASE + (16'(irq_num) << VEC_SHIFT));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      code_valid_r     <= 1'b0;
      redirect_valid_r <= 1'b1;
      redirect_addr_r  <= ROM_RESET_ADDR;
    end else begin
      code_valid_r <= rom_rd;
      if (code_take && is_jmp) begin
        redirect_valid_r <= 1'b1;
        redirect_addr_r  <= dpair_idx;
      end else if (irq_take) begin
        redirect_valid_r <= 1'b1;
        redirect_addr_r  <= vec_addr;
      end else begin
        redirect_valid_r <= 1'b0;
      end
    end
  end

  imm_ram imm_ram_inst (
    .core_clk (core_clk),
    .rstn     (rstn),
    .we       (ram_we),
    .addr     (ram_addr),
    .wdata    (ram_wdata),
    .rdata    (ram_q)
  );

  imm_rom imm_rom_inst (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .prog_we   (prog_we && prog_en),
    .prog_addr (prog_addr),
    .prog_data (prog_data),
    .rd_en     (rom_rd),
    .rd_addr   (rom_addr),
    .rd_data   (rom_q)
  );

  assign op_ready       = (state_r == IMM_IDLE);
  assign op_valid       = op_valid_r;
  assign op_err         = op_err_r;
  assign op_rdata       = op_rdata_r;
  assign code_ready     = !prog_en;
  assign code_valid     = code_valid_r;
  assign code_data      = rom_q;
  assign redirect_valid = redirect_valid_r;
  assign redirect_addr  = redirect_addr_r;
  assign bank_regs_base = {3'b000, bank_sel, 3'b000};

  // checks
  logic boot_seen_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boot_seen_r <= 1'b0;
    end else begin
      boot_seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_take;
    op_take;
  endsequence

  sequence s_done;
    ##1 !op_ready ##1 op_valid;
  endsequence

  AST_BOOT_VECTOR: assert property (
    !boot_seen_r |-> redirect_valid && redirect_addr == 16'h0000)
    else $error("first redirect after reset is not address zero");

  AST_IRQ_VECTOR: assert property (
    irq_take && !(code_take && is_jmp) |=> redirect_valid
      && redirect_addr == 16'h0003 + 16'($past(irq_num)) * 16'h0008)
    else $error("interrupt vector address wrong");

  AST_DIR_SFR: assert property (
    op_take && is_dir && op_addr[7] |-> !ram_we ##1 !ram_we)
    else $error("direct access above 7FH touched RAM");

  AST_IND_RAM: assert property (
    op_take && is_ind |-> ram_addr == op_addr && !sfr_wr)
    else $error("indirect access did not address RAM");

  AST_REG_BANK: assert property (
    op_take && is_reg |-> ram_addr[7:5] == 3'b000
      && ram_addr[4:3] == stat_r[STAT_BANK_MSB:STAT_BANK_LSB]
      && ram_addr[2:0] == op_addr[2:0])
    else $error("register access outside selected bank");

  AST_BIT_AREA: assert property (
    op_take && is_bit && !op_addr[7]
      |-> ram_addr == 8'h20 + {4'h0, op_addr[6:3]})
    else $error("bit address mapped outside 20H-2FH");

  AST_PUSH: assert property (
    op_take && is_push && !(sfr_wr && hit_stk) |-> ram_addr == stk_r + 8'h01
      ##1 stk_r == $past(stk_r) + 8'h01)
    else $error("push did not pre-increment the stack pointer");

  AST_OP_LATENCY: assert property (
    s_take |-> s_done)
    else $error("operand answer not two cycles after request");

  AST_UNIMPL_SFR: assert property (
    op_take && is_dir && op_addr[7] && !sfr_known && !op_we
      |-> ##2 op_valid && op_rdata == 8'h00)
    else $error("unimplemented SFR did not read zero");

  AST_TABLE_READ: assert property (
    code_take && code_kind == IMM_CODE_TBL_DP
      |-> rom_addr == {dph_r, dpl_r} + {8'h00, acc_r} ##1 code_valid)
    else $error("table read address is not pointer plus A");

  AST_JUMP: assert property (
    code_take && is_jmp |=> redirect_valid
      && redirect_addr == $past(dpair) + $past(acc16) && !code_valid)
    else $error("computed jump target wrong");

  AST_EXT_REFUSED: assert property (
    op_take && is_ext |-> !ram_we && !sfr_wr ##2 op_valid && op_err)
    else $error("external move was not refused");
endmodule // imm_map
`default_nettype wire

// ==== common/imm_pkg.sv ====
// Operation
// - program and data spaces are separate; data addresses are 8 bits wide
// - program store is read-only, at most 8K bytes, on chip, no external fetch
// - data store is only the 256-byte internal RAM, no expanded_ram
// - after reset the first fetch comes from program address zero
// - interrupt vectors sit 8 bytes apart starting at 0003H
// - direct operand address above 7FH selects special-function space
// - indirect operand address above 7FH selects upper RAM, not SFRs
// - lowest 32 RAM bytes are 4 banks of 8 working registers
// - 16 bytes above banks are bit-addressable as bits 00H to 7FH
// - lower 128 RAM bytes direct or indirect; upper 128 indirect only
// - SFRs direct only; those at x0H or x8H also allow bit access
// - indexed reads only program memory at 16-bit base plus accumulator
// - computed jump target is accumulator plus base pointer
// - implicit-register instructions carry no address byte
// - immediate operand is the program byte following the opcode
// - one data_pointer_pair; no external_move_instruction, no external data
// - code space read by fetch and by code_read_instruction
// - two program_status_word bits choose the active register bank
// - stack_top_register pre-increments on push and resets to 07H
`default_nettype none
package imm_pkg;
  localparam int          ROM_BYTES      = 8192;
  localparam int          ROM_AW         = 13;
  localparam int          RAM_BYTES      = 256;
  localparam logic [15:0] ROM_RESET_ADDR = 16'h0000;
  localparam logic [15:0] VEC_BASE       = 16'h0003;
  localparam int          VEC_SHIFT      = 3;
  localparam logic [7:0]  DIRECT_LIMIT   = 8'h7f;
  localparam logic [7:0]  BIT_AREA_BASE  = 8'h20;
  localparam logic [7:0]  SFR_STK        = 8'h81;
  localparam logic [7:0]  SFR_DPL        = 8'h82;
  localparam logic [7:0]  SFR_DPH        = 8'h83;
  localparam logic [7:0]  SFR_STAT       = 8'hd0;
  localparam logic [7:0]  SFR_ACC        = 8'he0;
  localparam logic [7:0]  STK_RESET      = 8'h07;
  localparam logic [7:0]  DPL_RESET      = 8'h00;
  localparam logic [7:0]  DPH_RESET      = 8'h00;
  localparam logic [7:0]  STAT_RESET     = 8'h00;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam int          STAT_BANK_LSB  = 3;
  localparam int          STAT_BANK_MSB  = 4;
  localparam int          OP_LATENCY     = 2;
  localparam int          CODE_LATENCY   = 1;

  typedef enum logic [2:0] {
    IMM_OP_DIR, IMM_OP_IND, IMM_OP_REG, IMM_OP_BIT,
    IMM_OP_PUSH, IMM_OP_POP, IMM_OP_EXT
  } imm_op_e;

  typedef enum logic [2:0] {
    IMM_CODE_FETCH, IMM_CODE_IMM, IMM_CODE_TBL_DP,
    IMM_CODE_TBL_PC, IMM_CODE_JMP
  } imm_code_e;
endpackage
`default_nettype wire

// ==== src/imm_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
module imm_ram (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       we,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  import imm_pkg::*;

  logic [7:0] mem [RAM_BYTES];
  logic [7:0] rdata_r;

  // only scratch RAM exists, 256 bytes, no expanded_ram port
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read gives the old byte on a same-cycle write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;
endmodule // imm_ram
`default_nettype wire

// ==== src/imm_rom.sv ====
`timescale 1ns/1ps
`default_nettype none
module imm_rom (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic                       prog_we,
  input  wire logic [imm_pkg::ROM_AW-1:0] prog_addr,
  input  wire logic [7:0]                 prog_data,
  input  wire logic                       rd_en,
  input  wire logic [15:0]                rd_addr,
  output logic      [7:0]                 rd_data
);
  import imm_pkg::*;

  logic [7:0] mem [ROM_BYTES];
  logic [7:0] rd_data_r;
  wire        in_range = (rd_addr[15:ROM_AW] == '0);

  // programming path only, open whenever prog_en is high; the core has no write port
  always_ff @(posedge core_clk) begin
    if (prog_we) begin
      mem[prog_addr] <= prog_data;
    end
  end

  // beyond 8K there is nothing to fetch: no external program store
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_r <= 8'h00;
    end else if (rd_en) begin
      rd_data_r <= in_range ? mem[rd_addr[ROM_AW-1:0]] : 8'h00;
    end
  end

  assign rd_data = rd_data_r;
endmodule // imm_rom
`default_nettype wire

// ==== sim/imm_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module imm_cpu_model (
  input  wire logic                core_clk,
  output logic                     op_req,
  output imm_pkg::imm_op_e         op_mode,
  output logic [7:0]               op_addr,
  output logic                     op_we,
  output logic [7:0]               op_wdata,
  input  wire logic                op_valid,
  input  wire logic                op_err,
  input  wire logic [7:0]          op_rdata,
  output logic                     code_req,
  output imm_pkg::imm_code_e       code_kind,
  output logic [15:0]              code_pc,
  input  wire logic                code_valid,
  input  wire logic [7:0]          code_data,
  input  wire logic                redirect_valid,
  input  wire logic [15:0]         redirect_addr,
  output logic                     irq_take,
  output logic [1:0]               irq_num,
  output logic                     prog_en,
  output logic                     prog_we,
  output logic [12:0]              prog_addr,
  output logic [7:0]               prog_data
);
  import imm_pkg::*;
  initial begin
    op_req    = 1'b0;
    op_mode   = IMM_OP_DIR;
    op_addr   = 8'h00;
    op_we     = 1'b0;
    op_wdata  = 8'h00;
    code_req  = 1'b0;
    code_kind = IMM_CODE_FETCH;
    code_pc   = 16'h0000;
    irq_take  = 1'b0;
    irq_num   = 2'h0;
    prog_en   = 1'b0;
    prog_we   = 1'b0;
    prog_addr = 13'h0000;
    prog_data = 8'h00;
  end
  // a lost answer leaves unknowns, so the caller's compare fails
  task automatic op(input imm_op_e m, input logic [7:0] a, input logic w,
                    input logic [7:0] d, output logic [7:0] rd,
                    output logic er);
    int n;
    n  = 0;
    rd = 8'hxx;
    er = 1'bx;
    @(negedge core_clk);
    op_req   = 1'b1;
    op_mode  = m;
    op_addr  = a;
    op_we    = w;
    op_wdata = d;
    @(posedge core_clk);
    @(negedge core_clk);
    op_req   = 1'b0;
    op_we    = 1'b0;
    op_addr  = ~a;
    op_wdata = ~d;
    while (op_valid !== 1'b1 && n < 4) begin
      n++;
      @(negedge core_clk);
    end
    if (op_valid === 1'b1) begin
      rd = op_rdata;
      er = op_err;
    end
  endtask
  task automatic code(input imm_code_e k, input logic [15:0] pc,
                      output logic [15:0] rd);
    @(negedge core_clk);
    code_req  = 1'b1;
    code_kind = k;
    code_pc   = pc;
    @(posedge core_clk);
    @(negedge core_clk);
    code_req  = 1'b0;
    code_pc   = ~pc;
    rd        = 16'hxxxx;
    if (k == IMM_CODE_JMP && redirect_valid === 1'b1)
      rd = redirect_addr;
    else if (k != IMM_CODE_JMP && code_valid === 1'b1)
      rd = {8'h00, code_data};
  endtask
  task automatic irq(input logic [1:0] n, output logic [15:0] rd);
    @(negedge core_clk);
    irq_take = 1'b1;
    irq_num  = n;
    @(posedge core_clk);
    @(negedge core_clk);
    irq_take = 1'b0;
    rd       = (redirect_valid === 1'b1) ? redirect_addr : 16'hxxxx;
  endtask
  task automatic prog(input logic [12:0] a, input logic [7:0] d);
    @(negedge core_clk);
    prog_en   = 1'b1;
    prog_we   = 1'b1;
    prog_addr = a;
    prog_data = d;
    @(posedge core_clk);
    @(negedge core_clk);
    prog_en   = 1'b0;
    prog_we   = 1'b0;
  endtask
endmodule // imm_cpu_model
`default_nettype wire

// ==== sim/imm_map_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module imm_map_tb;
  import imm_pkg::*;
  logic        core_clk, rstn, op_req, op_we, op_ready, op_valid, op_err;
  logic        code_req, code_ready, code_valid, irq_take, redirect_valid;
  logic        prog_en, prog_we;
  logic [7:0]  op_addr, op_wdata, op_rdata, code_data, prog_data, bank_base;
  logic [15:0] code_pc, redirect_addr, r16;
  logic [12:0] prog_addr;
  logic [1:0]  irq_num;
  imm_op_e     op_mode;
  imm_code_e   code_kind;
  int          err_total, num_checks;
  imm_map imm_map_inst (.core_clk(core_clk), .rstn(rstn), .op_req(op_req),
    .op_mode(op_mode), .op_addr(op_addr), .op_we(op_we),
    .op_wdata(op_wdata), .op_ready(op_ready), .op_valid(op_valid),
    .op_err(op_err), .op_rdata(op_rdata), .code_req(code_req),
    .code_kind(code_kind), .code_pc(code_pc), .code_ready(code_ready),
    .code_valid(code_valid), .code_data(code_data), .irq_take(irq_take),
    .irq_num(irq_num), .redirect_valid(redirect_valid),
    .redirect_addr(redirect_addr), .prog_en(prog_en), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data),
    .bank_regs_base(bank_base));
  imm_cpu_model imm_cpu_model_inst (.core_clk(core_clk), .op_req(op_req),
    .op_mode(op_mode), .op_addr(op_addr), .op_we(op_we),
    .op_wdata(op_wdata), .op_valid(op_valid), .op_err(op_err),
    .op_rdata(op_rdata), .code_req(code_req), .code_kind(code_kind),
    .code_pc(code_pc), .code_valid(code_valid), .code_data(code_data),
    .redirect_valid(redirect_valid), .redirect_addr(redirect_addr),
    .irq_take(irq_take), .irq_num(irq_num), .prog_en(prog_en),
    .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: addr got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input imm_op_e m, input logic [7:0] a,
                    input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    imm_cpu_model_inst.op(m, a, 1'b1, d, r, e);
  endtask
  task automatic rdc(input imm_op_e m, input logic [7:0] a,
                     input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    imm_cpu_model_inst.op(m, a, 1'b0, 8'h00, r, e);
    chk8(r, exp);
  endtask
  task automatic cdc(input imm_code_e k, input logic [15:0] pc,
                     input logic [15:0] exp);
    logic [15:0] r;
    imm_cpu_model_inst.code(k, pc, r);
    chk16(r, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset;
    chk8({6'h00, op_ready, code_ready}, 8'h03);
    rdc(IMM_OP_DIR, SFR_STK, 8'h07);
    chk8(bank_base, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_map;
    wr(IMM_OP_IND, 8'h90, 8'ha5);
    wr(IMM_OP_DIR, 8'h90, 8'h5a);
    rdc(IMM_OP_IND, 8'h90, 8'ha5);
    rdc(IMM_OP_DIR, 8'h90, 8'h00);
    wr(IMM_OP_IND, 8'he0, 8'h99);
    wr(IMM_OP_DIR, 8'he0, 8'h66);
    rdc(IMM_OP_IND, 8'he0, 8'h99);
    rdc(IMM_OP_DIR, 8'he0, 8'h66);
    wr(IMM_OP_DIR, 8'h30, 8'h3c);
    rdc(IMM_OP_IND, 8'h30, 8'h3c);
    wr(IMM_OP_IND, 8'h7f, 8'hc3);
    rdc(IMM_OP_DIR, 8'h7f, 8'hc3);
    $display("test map done");
  endtask
  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      wr(IMM_OP_DIR, SFR_STAT, 8'(b << 3));
      chk8(bank_base, 8'(b * 8));
      wr(IMM_OP_REG, 8'(7 - b), 8'(8'h40 + b));
      rdc(IMM_OP_IND, 8'(b * 8 + 7 - b), 8'(8'h40 + b));
      rdc(IMM_OP_REG, 8'(7 - b), 8'(8'h40 + b));
    end
    wr(IMM_OP_DIR, SFR_STAT, 8'h00);
    $display("test banks done");
  endtask
  task automatic t_bits;
    wr(IMM_OP_DIR, 8'h2f, 8'h00);
    wr(IMM_OP_BIT, 8'h7f, 8'h01);
    rdc(IMM_OP_DIR, 8'h2f, 8'h80);
    wr(IMM_OP_DIR, 8'h20, 8'h00);
    wr(IMM_OP_BIT, 8'h00, 8'h01);
    rdc(IMM_OP_DIR, 8'h20, 8'h01);
    rdc(IMM_OP_BIT, 8'h7e, 8'h00);
    wr(IMM_OP_DIR, SFR_ACC, 8'h08);
    rdc(IMM_OP_BIT, 8'he3, 8'h01);
    wr(IMM_OP_BIT, 8'he0, 8'h01);
    rdc(IMM_OP_DIR, SFR_ACC, 8'h09);
    $display("test bits done");
  endtask
  task automatic t_stack;
    wr(IMM_OP_PUSH, 8'h00, 8'h11);
    rdc(IMM_OP_IND, 8'h08, 8'h11);
    rdc(IMM_OP_DIR, SFR_STK, 8'h08);
    rdc(IMM_OP_POP, 8'h00, 8'h11);
    rdc(IMM_OP_DIR, SFR_STK, 8'h07);
    $display("test stack done");
  endtask
  task automatic t_ext;
    logic [7:0] r;
    logic       e;
    imm_cpu_model_inst.op(IMM_OP_EXT, 8'h30, 1'b1, 8'hff, r, e);
    chk8(r, 8'h00);
    chk8({7'h00, e}, 8'h01);
    rdc(IMM_OP_DIR, 8'h30, 8'h3c);
    $display("test ext done");
  endtask
  task automatic t_code;
    imm_cpu_model_inst.prog(13'h0000, 8'h12);
    imm_cpu_model_inst.prog(13'h0001, 8'h34);
    imm_cpu_model_inst.prog(13'h0002, 8'h56);
    imm_cpu_model_inst.prog(13'h1ffe, 8'h9a);
    wr(IMM_OP_DIR, 8'h00, 8'h77);
    cdc(IMM_CODE_FETCH, 16'h0000, 16'h0012);
    cdc(IMM_CODE_IMM, 16'h0000, 16'h0034);
    wr(IMM_OP_DIR, SFR_DPL, 8'hf0);
    wr(IMM_OP_DIR, SFR_DPH, 8'h1f);
    wr(IMM_OP_DIR, SFR_ACC, 8'h0e);
    cdc(IMM_CODE_TBL_DP, 16'h0000, 16'h009a);
    cdc(IMM_CODE_JMP, 16'h0000, 16'h1ffe);
    wr(IMM_OP_DIR, SFR_ACC, 8'h02);
    cdc(IMM_CODE_TBL_PC, 16'h0000, 16'h0056);
    wr(IMM_OP_DIR, SFR_DPH, 8'h20);
    cdc(IMM_CODE_TBL_DP, 16'h0000, 16'h0000);
    cdc(IMM_CODE_FETCH, 16'h2000, 16'h0000);
    $display("test code done");
  endtask
  task automatic t_irq;
    for (int n = 0; n < 4; n++) begin
      imm_cpu_model_inst.irq(2'(n), r16);
      chk16(r16, 16'(16'h0003 + 8 * n));
    end
    $display("test irq done");
  endtask
  initial begin
    err_total  = 0;
    num_checks = 0;
    rstn       = 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk8({7'h00, redirect_valid}, 8'h01);
    chk16(redirect_addr, 16'h0000);
    rstn = 1'b1;
    t_reset();
    t_map();
    t_banks();
    t_bits();
    t_stack();
    t_ext();
    t_code();
    t_irq();
    end_sim();
  end
  // whole run is a few hundred cycles; this is generous
  initial begin
    #500000;
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule // imm_map_tb
`default_nettype wire
